// *** common/isp_pkg.sv ***
// isp_pkg: constants shared by both ends of the serial register port
// assumes: controller on a 20 MHz pclk, target on its own link clock
package isp_pkg;

  // ----------------------------------------------------------------
  // bus rates and controller timing
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_HZ    = 20_000_000;
  localparam int unsigned SCL_STD_HZ = 100_000;    // standard-mode rate
  localparam int unsigned SCL_HS_HZ  = 3_400_000;  // high-speed rate
  // pclk cycles per quarter scl period at the standard rate
  localparam logic [7:0] QTR_RST = 8'(PCLK_HZ / (4 * SCL_STD_HZ));
  // fastest quarter the controller's input sampling can keep up with
  localparam logic [7:0] QTR_FLOOR = 8'h02;

  // ----------------------------------------------------------------
  // controller registers (apb byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD  = 8'h00;  // write starts a transfer
  localparam logic [7:0] REG_DIV  = 8'h04;  // quarter-period count
  localparam logic [7:0] REG_STAT = 8'h08;  // busy, nack, read data
  localparam int CMD_DATA_LSB  = 0;
  localparam int CMD_OFFS_LSB  = 8;
  localparam int CMD_RD_BIT    = 16;
  localparam int CMD_TADDR_LSB = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RD_LSB   = 8;

  // ----------------------------------------------------------------
  // target register space
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ADDR_SEL  = 8'h92;  // bus_address_select
  localparam logic [7:0] ADDR_SEL_MASK = 8'h03;  // reserved bits read 0
  localparam logic [7:0] REG_RST       = 8'h00;
  localparam logic [6:0] TADDR_0 = 7'h5e;
  localparam logic [6:0] TADDR_1 = 7'h6e;
  localparam logic [6:0] TADDR_2 = 7'h4f;
  localparam logic [6:0] TADDR_3 = 7'h77;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TS_IDLE = 3'h0, TS_ADDR = 3'h1, TS_RX = 3'h2, TS_ACK = 3'h3,
    TS_TX = 3'h4, TS_HACK = 3'h5, TS_IGNORE = 3'h6
  } isp_tstate_e;

  typedef enum logic [1:0] {
    CS_IDLE = 2'h0, CS_START = 2'h1, CS_BYTE = 2'h2, CS_STOP = 2'h3
  } isp_cstate_e;

  // select code to 7-bit target address
  function automatic logic [6:0] target_addr(input logic [1:0] sel);
    case (sel)
      2'h0:    target_addr = TADDR_0;
      2'h1:    target_addr = TADDR_1;
      2'h2:    target_addr = TADDR_2;
      default: target_addr = TADDR_3;
    endcase
  endfunction : target_addr

endpackage : isp_pkg

// *** common/isp_link_if.sv ***
// isp_link_if: the two open-drain wires between controller and target
// assumes: pull-ups, so a wire reads low only while someone drives it
`timescale 1ns/1ps
interface isp_link_if;
  logic ctrl_scl_o;   // controller clock drive value
  logic ctrl_scl_oe;  // controller drives clock
  logic ctrl_sda_o;   // controller data drive value
  logic ctrl_sda_oe;  // controller drives data
  logic tgt_sda_o;    // target data drive value
  logic tgt_sda_oe;   // target drives data
  logic scl_i;        // resolved clock wire
  logic sda_i;        // resolved data wire

  // wired-and resolution with pull-up
  assign scl_i = ~(ctrl_scl_oe & ~ctrl_scl_o);
  assign sda_i = ~((ctrl_sda_oe & ~ctrl_sda_o) |
                   (tgt_sda_oe & ~tgt_sda_o));

  modport ctrl (output ctrl_scl_o, ctrl_scl_oe, ctrl_sda_o, ctrl_sda_oe,
                input scl_i, sda_i);
  modport target (output tgt_sda_o, tgt_sda_oe, input scl_i, sda_i);
endinterface : isp_link_if

// *** logic/isp_target.sv ***
// isp_target: serial bus target with a flat 256-byte register space
// assumes: link_clk oversamples scl by at least 4x, controller obeys
// the bus framing; platform_reset_n is the platform reset pin
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module isp_target (
  input  wire logic  link_clk,
  input  wire logic  platform_reset_n,
  isp_link_if.target bus,
  output logic [1:0] target_address_select,
  output logic       wr_strobe_q,
  output logic [7:0] wr_offset_q,
  output logic [7:0] wr_data_q
);

  // ----------------------------------------------------------------
  // reset release synchroniser
  // ----------------------------------------------------------------
  // the reset pin has no relation to link_clk: assert at once, but
  // release two edges later so no flop sees the release mid-setup
  logic [1:0] rst_sq;             // [1] is the local reset, low active
  wire        rst_n = rst_sq[1];  // releases in step with link_clk

  always_ff @(posedge link_clk or negedge platform_reset_n) begin
    if (!platform_reset_n) begin
      rst_sq <= 2'h0;
    end else begin
      rst_sq <= {rst_sq[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // [0] first flop, [1] second flop, [2] history for edges
  logic [2:0] scl_sq;
  logic [2:0] sda_sq;

  // only [1] and [2] feed logic; [0] may be metastable
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sq <= 3'h7;
      sda_sq <= 3'h7;
    end else begin
      scl_sq <= {scl_sq[1:0], bus.scl_i};
      sda_sq <= {sda_sq[1:0], bus.sda_i};
    end
  end

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  wire scl_hi   = scl_sq[1] & scl_sq[2];
  wire sda_now  = sda_sq[1];
  // data falling or rising under a high clock frames a transfer
  wire start_ev = scl_hi & sda_sq[2] & ~sda_sq[1];
  wire stop_ev  = scl_hi & ~sda_sq[2] & sda_sq[1];
  wire scl_rise = scl_sq[1] & ~scl_sq[2];
  wire scl_fall = ~scl_sq[1] & scl_sq[2];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  isp_pkg::isp_tstate_e state_q;   // protocol phase
  logic [3:0]           cnt_q;     // bit count in current byte
  logic [7:0]           sh_q;      // receive shifter
  logic [7:0]           tx_q;      // transmit shifter
  logic [7:0]           ptr_q;     // register offset pointer
  logic                 offs_q;    // offset byte already taken
  logic                 rw_q;      // direction of this address phase
  logic                 sda_oe_q;  // pulls data low when high
  logic [7:0]           regs_q [256];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [1:0] addr_sel = regs_q[isp_pkg::REG_ADDR_SEL][1:0];
  wire       rx_done  = scl_fall & (cnt_q == 4'h8);
  // compare against whichever address software picked
  wire       addr_hit =
    (sh_q[7:1] == isp_pkg::target_addr(addr_sel));
  wire [7:0] rd_byte  = regs_q[ptr_q];
  wire       in_rx    = (state_q == isp_pkg::TS_RX);
  // a data byte after the offset byte is a register write
  wire       wr_go    = in_rx & rx_done & offs_q;
  wire [7:0] ptr_inc  = ptr_q + 8'h01; // wraps ff to 00
  // reserved bits of the select register never store
  wire [7:0] wr_val   = (ptr_q == isp_pkg::REG_ADDR_SEL) ?
                        (sh_q & isp_pkg::ADDR_SEL_MASK) : sh_q;

  // data pin only ever pulls low; clock has no driver here
  assign bus.tgt_sda_o  = 1'b0;
  assign bus.tgt_sda_oe = sda_oe_q;
  assign target_address_select = regs_q[isp_pkg::REG_ADDR_SEL][1:0];

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  // everything moves on sampled scl edges or on start and stop, so the controller sets the
  // pace and no cycle is ever held back
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= isp_pkg::TS_IDLE;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      offs_q   <= 1'b0;
      rw_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_ev) begin
      // start or repeated start: keep the pointer for reads
      state_q  <= isp_pkg::TS_ADDR;
      cnt_q    <= 4'h0;
      offs_q   <= 1'b0;
      rw_q     <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (stop_ev) begin
      // stop from any controller ends our part
      state_q  <= isp_pkg::TS_IDLE;
      offs_q   <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (state_q)
        isp_pkg::TS_ADDR, isp_pkg::TS_RX: begin
          if (scl_rise) begin
            // data is stable while clock is high
            sh_q  <= {sh_q[6:0], sda_now};
            cnt_q <= cnt_q + 4'h1;
          end else if (rx_done && !in_rx) begin
            if (addr_hit) begin
              sda_oe_q <= 1'b1;
              rw_q     <= sh_q[0];
              state_q  <= isp_pkg::TS_ACK;
            end else begin
              // stay released until next start or stop
              state_q <= isp_pkg::TS_IGNORE;
            end
          end else if (rx_done) begin
            sda_oe_q <= 1'b1;
            offs_q   <= 1'b1;
            state_q  <= isp_pkg::TS_ACK;
            if (!offs_q) begin
              ptr_q <= sh_q; // first byte is the offset
            end else begin
              ptr_q <= ptr_inc; // burst write
            end
          end
        end
        isp_pkg::TS_ACK: begin
          // ack slot ends when the controller drops the clock
          if (scl_fall) begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              tx_q     <= rd_byte;
              ptr_q    <= ptr_inc; // burst read
              sda_oe_q <= ~rd_byte[7];
              state_q  <= isp_pkg::TS_TX;
            end else begin
              sda_oe_q <= 1'b0;
              state_q  <= isp_pkg::TS_RX;
            end
          end
        end
        isp_pkg::TS_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              // hand the line over for the controller's answer
              sda_oe_q <= 1'b0;
              state_q  <= isp_pkg::TS_HACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
              cnt_q    <= cnt_q + 4'h1;
            end
          end
        end
        isp_pkg::TS_HACK: begin
          if (scl_rise) begin
            // a nack ends the read; an ack asks for the next byte
            state_q <= sda_now ? isp_pkg::TS_IGNORE : isp_pkg::TS_ACK;
          end
        end
        isp_pkg::TS_IDLE, isp_pkg::TS_IGNORE: begin
          sda_oe_q <= 1'b0;
        end
        default: begin
          state_q  <= isp_pkg::TS_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register space
  // ----------------------------------------------------------------
  // plain flops; every byte clears with the platform reset
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        regs_q[i] <= isp_pkg::REG_RST;
      end
    end else if (wr_go) begin
      regs_q[ptr_q] <= wr_val;
    end
  end

  // ----------------------------------------------------------------
  // write report to surrounding logic
  // ----------------------------------------------------------------
  // one link_clk pulse per stored byte, carrying offset and value
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_strobe_q <= 1'b0;
      wr_offset_q <= 8'h00;
      wr_data_q   <= 8'h00;
    end else begin
      wr_strobe_q <= wr_go;
      if (wr_go) begin
        wr_offset_q <= ptr_q;
        wr_data_q   <= wr_val;
      end
    end
  end

endmodule : isp_target

// *** logic/isp_ctrl.sv ***
// isp_ctrl: bus controller that reaches the target's registers
// assumes: apb master on pclk; pull-ups on the wires; one byte per
// command, single controller unless a debugger shares the bus
`timescale 1ns/1ps
module isp_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  isp_link_if.ctrl         bus
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  isp_pkg::isp_cstate_e state_q;
  logic [1:0] phase_q;    // quarter of the current bit slot
  logic [7:0] qcnt_q;     // pclk count inside a quarter
  logic [3:0] bit_q;      // bit of byte, 8 is the ack slot
  logic [2:0] step_q;     // which byte of the transfer
  logic [7:0] div_q;      // quarter length in pclk cycles
  logic [6:0] taddr_q;    // target address
  logic [7:0] offs_q;     // register offset
  logic [7:0] wdata_q;    // byte to write
  logic       rd_q;       // command is a read
  logic       busy_q;
  logic       nack_q;
  logic [7:0] rdata_q;
  logic [1:0] sda_sq;     // [0] first sync flop
  logic       scl_oe_q;
  logic       sda_oe_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pready & pwrite;
  wire hit = (paddr == isp_pkg::REG_CMD) | (paddr == isp_pkg::REG_DIV) |
             (paddr == isp_pkg::REG_STAT);
  wire go  = apb_wr & (paddr == isp_pkg::REG_CMD) & ~busy_q;
  wire [31:0] stat_w = {16'h0000, rdata_q, 6'h00, nack_q, busy_q};
  wire [31:0] rmux =
    (paddr == isp_pkg::REG_STAT) ? stat_w :
    (paddr == isp_pkg::REG_DIV)  ? {24'h000000, div_q} : 32'h00000000;

  // ----------------------------------------------------------------
  // sequencer decode
  // ----------------------------------------------------------------
  wire tick     = busy_q & (qcnt_q == div_q - 8'h01);
  wire slot_end = tick & (phase_q == 2'h3);
  wire sample   = tick & (phase_q == 2'h2);
  wire rx_step  = (step_q == 3'h4);
  wire sda_in   = sda_sq[1];
  wire [7:0] tx_byte =
    (step_q == 3'h0) ? {taddr_q, 1'b0} :           // write direction
    (step_q == 3'h1) ? offs_q :
    (step_q == 3'h2) ? wdata_q : {taddr_q, 1'b1};  // read direction
  // data bit this slot would pull low
  wire tx_low = ~rx_step & (bit_q != 4'h8) & ~tx_byte[3'h7 - bit_q[2:0]];
  wire q_mid  = (phase_q == 2'h1) | (phase_q == 2'h2);
  wire scl_low_w =
    (state_q == isp_pkg::CS_START) ? (phase_q == 2'h0) | (phase_q == 2'h3) :
    (state_q == isp_pkg::CS_BYTE)  ? ~q_mid :
    (state_q == isp_pkg::CS_STOP)  ? (phase_q == 2'h0) : 1'b0;
  wire sda_low_w =
    (state_q == isp_pkg::CS_START) ? phase_q[1] :
    (state_q == isp_pkg::CS_BYTE)  ? tx_low :
    (state_q == isp_pkg::CS_STOP)  ? ~phase_q[1] : 1'b0;

  assign bus.ctrl_scl_o  = 1'b0;
  assign bus.ctrl_sda_o  = 1'b0;
  assign bus.ctrl_scl_oe = scl_oe_q;
  assign bus.ctrl_sda_oe = sda_oe_q;

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      div_q   <= isp_pkg::QTR_RST;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~hit;
      prdata  <= (apb_setup & ~pwrite) ? rmux : 32'h00000000;
      // too short a quarter would outrun the input synchroniser
      if (apb_wr && paddr == isp_pkg::REG_DIV) begin
        div_q <= (pwdata[7:0] < isp_pkg::QTR_FLOOR) ?
                 isp_pkg::QTR_FLOOR : pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pins: registered drive and data synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sq   <= 2'h3;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      sda_sq   <= {sda_sq[0], bus.sda_i};
      scl_oe_q <= scl_low_w;
      sda_oe_q <= sda_low_w;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer: start, bytes, optional restart, stop
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= isp_pkg::CS_IDLE;
      phase_q <= 2'h0;
      qcnt_q  <= 8'h00;
      bit_q   <= 4'h0;
      step_q  <= 3'h0;
      taddr_q <= 7'h00;
      offs_q  <= 8'h00;
      wdata_q <= 8'h00;
      rd_q    <= 1'b0;
      busy_q  <= 1'b0;
      nack_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else if (go) begin
      taddr_q <= pwdata[isp_pkg::CMD_TADDR_LSB +: 7];
      offs_q  <= pwdata[isp_pkg::CMD_OFFS_LSB +: 8];
      wdata_q <= pwdata[isp_pkg::CMD_DATA_LSB +: 8];
      rd_q    <= pwdata[isp_pkg::CMD_RD_BIT];
      busy_q  <= 1'b1;
      nack_q  <= 1'b0;
      state_q <= isp_pkg::CS_START;
      phase_q <= 2'h0;
      qcnt_q  <= 8'h00;
      step_q  <= 3'h0;
    end else if (busy_q) begin
      qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;
      if (tick) begin
        phase_q <= phase_q + 2'h1;
      end
      if (sample && state_q == isp_pkg::CS_BYTE) begin
        if (rx_step && bit_q != 4'h8) begin
          rdata_q <= {rdata_q[6:0], sda_in};
        end else if (!rx_step && bit_q == 4'h8 && sda_in) begin
          nack_q <= 1'b1;
        end
      end
      if (slot_end) begin
        case (state_q)
          isp_pkg::CS_START: begin
            state_q <= isp_pkg::CS_BYTE;
            bit_q   <= 4'h0;
          end
          isp_pkg::CS_BYTE: begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              // a refused byte, last write or the read ends it
              if (nack_q || rx_step || step_q == 3'h2) begin
                state_q <= isp_pkg::CS_STOP;
              end else if (step_q == 3'h1 && rd_q) begin
                state_q <= isp_pkg::CS_START;
                step_q  <= 3'h3;
              end else begin
                step_q <= step_q + 3'h1;
              end
            end
          end
          isp_pkg::CS_STOP: begin
            state_q <= isp_pkg::CS_IDLE;
            busy_q  <= 1'b0;
          end
          default: begin
            state_q <= isp_pkg::CS_IDLE;
            busy_q  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : isp_ctrl

// *** verification/isp_link_monitor.sv ***
// isp_link_monitor: checks on the two shared wires of the register port
// assumes: sits beside the link interface; pull-ups on both wires
`timescale 1ns/1ps
module isp_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_clk,
  input wire logic platform_reset_n,
  input wire logic ctrl_scl_o,
  input wire logic ctrl_scl_oe,
  input wire logic ctrl_sda_o,
  input wire logic ctrl_sda_oe,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  input wire logic scl_i,
  input wire logic sda_i
);
  // ------------------------------------------------------------
  // target end, link clock domain
  // ------------------------------------------------------------
  a_tgt_open_drain: assert property (
    @(posedge link_clk) disable iff (!platform_reset_n)
    tgt_sda_oe |-> !tgt_sda_o) else $error("target drives sda high");
  // no disable here: the reset itself is the cause under test
  a_rst_quiet: assert property (
    @(posedge link_clk) !platform_reset_n |-> !tgt_sda_oe)
    else $error("target drives sda in reset");
  a_hold_scl_high: assert property (
    @(posedge link_clk) disable iff (!platform_reset_n)
    scl_i && $past(scl_i) |-> $stable(tgt_sda_oe))
    else $error("target sda moved while scl high");
  // sync lag means a change never lands on the first low sample
  a_move_late: assert property (
    @(posedge link_clk) disable iff (!platform_reset_n)
    $changed(tgt_sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("target sda moved outside scl low");
  // ------------------------------------------------------------
  // wire level, controller clock domain
  // ------------------------------------------------------------
  a_scl_ctrl_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    !scl_i |-> ctrl_scl_oe) else $error("scl low with no driver");
  a_ctrl_open_drain: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_scl_oe |-> !ctrl_scl_o) and (ctrl_sda_oe |-> !ctrl_sda_o))
    else $error("controller drives a wire high");
  a_no_fight: assert property (
    @(posedge pclk) disable iff (!presetn)
    scl_i && tgt_sda_oe |-> !ctrl_sda_oe)
    else $error("both ends drive sda in scl high");
  a_no_tgt_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(sda_i) && scl_i && $past(scl_i) |-> ctrl_sda_oe)
    else $error("start condition not from controller");
endmodule : isp_link_monitor

// *** verification/i2c_slave_register_port_test.sv ***
// testbench: controller and target joined by the link interface
// assumes: apb master here; target on its own 12 ns link clock
`timescale 1ns/1ps
module i2c_slave_register_port_test;
  logic pclk = 0, link_clk = 0, presetn, platform_reset_n;
  logic psel, penable, pwrite, pready, pslverr, wr_strobe_q;
  logic [7:0] paddr, wr_offset_q, wr_data_q;
  logic [31:0] pwdata, prdata, r, st;
  logic [1:0] target_address_select;
  logic e;
  logic [6:0] ta [4];
  int num_errors = 0, samples_checked = 0, cyc = 0, nstb = 0;
  always #25 pclk = ~pclk;
  always #6 link_clk = ~link_clk; // 12 ns, edges meet pclk's every 150 ns
  isp_link_if i_isp_link_if ();
  isp_ctrl i_isp_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus(i_isp_link_if.ctrl));
  isp_target i_isp_target (.link_clk(link_clk),
    .platform_reset_n(platform_reset_n), .bus(i_isp_link_if.target),
    .target_address_select(target_address_select),
    .wr_strobe_q(wr_strobe_q), .wr_offset_q(wr_offset_q),
    .wr_data_q(wr_data_q));
  isp_link_monitor i_isp_link_monitor (.pclk(pclk), .presetn(presetn),
    .link_clk(link_clk), .platform_reset_n(platform_reset_n),
    .ctrl_scl_o(i_isp_link_if.ctrl_scl_o),
    .ctrl_scl_oe(i_isp_link_if.ctrl_scl_oe),
    .ctrl_sda_o(i_isp_link_if.ctrl_sda_o),
    .ctrl_sda_oe(i_isp_link_if.ctrl_sda_oe),
    .tgt_sda_o(i_isp_link_if.tgt_sda_o),
    .tgt_sda_oe(i_isp_link_if.tgt_sda_oe),
    .scl_i(i_isp_link_if.scl_i), .sda_i(i_isp_link_if.sda_i));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // count stored bytes so stray writes show up
  always @(posedge link_clk) if (wr_strobe_q === 1'b1) nstb++;
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string n, input logic [31:0] x, y);
    samples_checked++;
    if (y !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // one bus byte through the controller, then poll until idle
  task automatic cmd(input logic [6:0] t, input logic rd,
                     input logic [7:0] of, dt);
    apb(1, isp_pkg::REG_CMD, {1'b0, t, 7'h0, rd, of, dt});
    do apb(0, isp_pkg::REG_STAT, 0); while (r[0] !== 1'b0);
    st = r;
  endtask : cmd
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    ta = '{isp_pkg::TADDR_0, isp_pkg::TADDR_1, isp_pkg::TADDR_2,
           isp_pkg::TADDR_3};
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 0;
    platform_reset_n = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    platform_reset_n <= 1;
    repeat (4) @(posedge pclk);
    apb(0, isp_pkg::REG_DIV, 0);
    chk("div_reset", {24'h0, isp_pkg::QTR_RST}, r);
    apb(1, isp_pkg::REG_DIV, 0); // below floor, fastest rate results
    apb(0, isp_pkg::REG_DIV, 0);
    chk("div_floor", {24'h0, isp_pkg::QTR_FLOOR}, r);
    apb(0, 8'h0c, 0);
    chk("unmapped", 32'h1, {r[30:0], e});
    $display("test controller registers done");
    cmd(ta[0], 1, isp_pkg::REG_ADDR_SEL, 0);
    chk("sel_reset", 32'h0, {st[15:8], st[1]});
    for (int i = 0; i < 4; i++) begin
      // the previous select still rules, and on the first pass it is 0
      cmd(ta[(i == 0) ? 0 : i - 1], 0, isp_pkg::REG_ADDR_SEL,
          8'hfc | 8'(i));
      chk("sel_wr_nack", 0, st[1]);
      chk("sel_out", i, target_address_select);
      cmd(ta[i], 1, isp_pkg::REG_ADDR_SEL, 0);
      chk("sel_rd", 8'(i) & isp_pkg::ADDR_SEL_MASK, st[15:8]);
      cmd(ta[(i + 3) % 4], 1, 8'h00, 0);
      chk("old_addr_nack", 1, st[1]);
    end
    cmd(ta[3], 0, isp_pkg::REG_ADDR_SEL, 8'h00);
    chk("sel_restore", 0, st[1]);
    $display("test address select done");
    for (int i = 0; i < 3; i++) begin
      cmd(ta[0], 0, 8'h7f * 8'(i) + 8'(i / 2), 8'h5a ^ 8'(i * 99));
      chk("wr_offset", 8'h7f * 8'(i) + 8'(i / 2), wr_offset_q);
      chk("wr_data", 8'h5a ^ 8'(i * 99), wr_data_q);
    end
    for (int i = 0; i < 3; i++) begin
      cmd(ta[0], 1, 8'h7f * 8'(i) + 8'(i / 2), 0);
      chk("rd_back", 8'h5a ^ 8'(i * 99), st[15:8]);
    end
    chk("strobes", 8, nstb);
    cmd(7'h10, 0, 8'h20, 8'h11);
    chk("foreign_nack", 1, st[1]);
    chk("foreign_store", 8'hff, wr_offset_q);
    $display("test data path done");
    // move the select away so the reset value of the field shows
    cmd(ta[0], 0, isp_pkg::REG_ADDR_SEL, 8'h02);
    chk("sel_set", 2, target_address_select);
    platform_reset_n <= 0;
    cmd(ta[2], 1, 8'h7f, 0);
    chk("rst_nack", 1, st[1]);
    platform_reset_n <= 1;
    repeat (4) @(posedge pclk);
    chk("sel_rst", 0, target_address_select);
    cmd(ta[0], 1, 8'h7f, 0);
    chk("rst_clear", 0, {st[15:8], st[1]});
    $display("test platform reset done");
    tally_and_finish();
  end
endmodule : i2c_slave_register_port_test
